// >>> hw/asc_alu_shift_ctrl.v
// ALU function, carry, mode and shifter control with zero detection
`timescale 1ns/1ps
`include "asc_defines.vh"

// Summary of operation
// - drive four selects, carry, mode, two shifter selects
// - plain cycles take main microword fields
// - field seven selects subsidiary ROM outputs
// - three-bit field decoded, not bit-mapped
// - field codes pick the listed ALU operations
// - mode logic for 0,1,4; arithmetic for 2,3,5,6
// - low two selects follow ROM directly
// - high two selects blocked during byte swap
// - negative sign extend forces arithmetic mode
// - rotate, add carry, subtract carry force arithmetic
// - ROM mode and carry both set: data carry
// - two-word shifts carry in low word MSB
// - carry in from C, inverted for subtract
// - byte sign extend during byte move
// - flag high byte significant, sign bit 15
// - shifter selects from ROM, forced swap
// - word zero needs both bytes zero
// - byte zero tests low byte only
// - odd byte or swap tests high byte
// - two-word check clears Z on nonzero word
// - divide saves carry out each subtract cycle
// - odd byte flag loads with destination register
// - carry output feeds ALU least significant bit
module asc_alu_shift_ctrl #(
   parameter ROM_AW = 4,
   parameter ROM_DEPTH = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [2:0] alu_control_field,
   input wire [1:0] shift_control_field,
   input wire [ROM_AW-1:0] instr_index,
   input wire cin_req,
   input wire c_bit,
   input wire sign_bit,
   input wire low_word_msb,
   input wire alu_carry_out,
   input wire div_sub_cycle,
   input wire swap_bytes_instr,
   input wire byte_swap_req,
   input wire sign_extend_word_instr,
   input wire rotate_left_instr,
   input wire add_carry_instr,
   input wire subtract_carry_instr,
   input wire divide_instr,
   input wire combined_arith_shift_instr,
   input wire move_byte_instr,
   input wire byte_op,
   input wire odd_byte_op,
   input wire [15:0] shifter_output,
   input wire two_word_zero_check,
   input wire z_bit,
   input wire dr_load,
   input wire dr_load_bit,
   output reg [3:0] alu_function_select,
   output reg alu_carry_in,
   output reg alu_mode,
   output reg [1:0] shifter_select,
   output reg instr_dependent_select,
   output reg byte_sign_extend,
   output reg high_byte_significant,
   output reg zero_detect,
   output reg divide_subtract_save,
   output reg odd_byte_dest
);

   // Decode of plain field: {carry, mode, function select}
   function [5:0] asc_plain_dec;
      input [2:0] f;
      input cin;
      reg [3:0] fs;
      reg m;
      reg c;
      begin
         fs = `ASC_FS_NOT_A;
         m = 1'b1;
         c = 1'b0;
         case (f)
            `ASC_ALU_CONTROL_FIELD_NOT_A: begin
               fs = `ASC_FS_NOT_A;
               m = 1'b1;
               c = 1'b0;
            end
            `ASC_ALU_CONTROL_FIELD_PASS_B: begin
               fs = `ASC_FS_PASS_B;
               m = 1'b1;
               c = 1'b0;
            end
            `ASC_ALU_CONTROL_FIELD_A_C: begin
               fs = `ASC_FS_A;
               m = 1'b0;
               c = cin;
            end
            `ASC_ALU_CONTROL_FIELD_AB_C: begin
               fs = `ASC_FS_A_PLUS_B;
               m = 1'b0;
               c = cin;
            end
            `ASC_ALU_CONTROL_FIELD_AA_C: begin
               fs = `ASC_FS_A_PLUS_A;
               m = 1'b0;
               c = cin;
            end
            `ASC_ALU_CONTROL_FIELD_A_MIN_B: begin
               fs = `ASC_FS_A_MIN_B;
               m = 1'b0;
               c = 1'b1;
            end
            // Unused code: harmless NOT A in logic mode, flagged in sticky reg
            default: begin
               fs = `ASC_FS_NOT_A;
               m = 1'b1;
               c = 1'b0;
            end
         endcase
         asc_plain_dec = {c, m, fs};
      end
   endfunction

   // ROM window hit, shared by the write path and the read mux
   function asc_rom_hit;
      input [7:0] a;
      begin
         asc_rom_hit = (a >= `ASC_OFS_ROM_BASE) && (a <= `ASC_OFS_ROM_LAST);
      end
   endfunction

   function [ROM_AW-1:0] asc_rom_idx;
      input [7:0] a;
      begin
         asc_rom_idx = a[ROM_AW+1:2];
      end
   endfunction

   function asc_zero8;
      input [7:0] b;
      begin
         asc_zero8 = ~|b;
      end
   endfunction

   // Subsidiary control ROM, loadable over the bus
   reg [7:0] rom_q [0:ROM_DEPTH-1];
   wire [7:0] rom_word;
   assign rom_word = rom_q[instr_index];

   // Bus address phase capture
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   reg unused_seen_q;
   wire addr_ok;
   wire rom_hit_wr;
   wire [ROM_AW-1:0] wr_idx;
   assign addr_ok = hsel & hready & htrans[1];
   assign rom_hit_wr = asc_rom_hit(wr_addr_q);
   assign wr_idx = asc_rom_idx(wr_addr_q);

   // Next values of the control outputs
   reg [3:0] fs_d;
   reg cin_d;
   reg mode_d;
   reg [1:0] shf_d;
   reg ins_dep_d;
   reg zero_d;
   reg [5:0] plain;
   reg special_carry;
   reg lo_z;
   reg hi_z;

   // Source select and function select lines
   always @* begin
      plain = asc_plain_dec(alu_control_field, cin_req);
      ins_dep_d = (alu_control_field == `ASC_ALU_CONTROL_FIELD_INS_DEP);
      fs_d = plain[3:0];
      if (ins_dep_d) begin
         // Low selects always pass through
         fs_d[1:0] = rom_word[1:0];
         if (swap_bytes_instr) begin
            fs_d[3:2] = 2'b00;
         end else begin
            fs_d[3:2] = rom_word[`ASC_ROM_FS_MSB:2];
         end
      end
   end

   // Mode line; forcing only touches instruction-dependent cycles
   always @* begin
      mode_d = plain[4];
      if (ins_dep_d) begin
         mode_d = rom_word[`ASC_ROM_MODE];
         if (sign_extend_word_instr & sign_bit) begin
            mode_d = 1'b0;
         end
         if (rotate_left_instr | add_carry_instr |
             subtract_carry_instr) begin
            mode_d = 1'b0;
         end
      end
   end

   // Carry in; special carry judged on raw ROM bits, not forced mode
   always @* begin
      special_carry = rom_word[`ASC_ROM_MODE] &
                      rom_word[`ASC_ROM_CARRY];
      cin_d = plain[5];
      if (ins_dep_d) begin
         cin_d = rom_word[`ASC_ROM_CARRY];
         if (special_carry) begin
            if (divide_instr | combined_arith_shift_instr) begin
               cin_d = low_word_msb;
            end else if (add_carry_instr | rotate_left_instr) begin
               cin_d = c_bit;
            end else if (subtract_carry_instr) begin
               cin_d = ~c_bit;
            end else begin
               cin_d = 1'b0;
            end
         end
      end
   end

   // Shifter selects
   always @* begin
      shf_d = shift_control_field;
      if (ins_dep_d) begin
         shf_d = rom_word[`ASC_ROM_SHF_MSB:`ASC_ROM_SHF_LSB];
         if (swap_bytes_instr | byte_swap_req) begin
            shf_d = `ASC_SHF_SWAP;
         end
      end
   end

   // Zero detect over the significant bytes only
   always @* begin
      lo_z = asc_zero8(shifter_output[7:0]);
      hi_z = asc_zero8(shifter_output[15:8]);
      if (two_word_zero_check) begin
         // Second word may only clear Z, never set it
         zero_d = z_bit & lo_z & hi_z;
      end else if (odd_byte_op | swap_bytes_instr) begin
         zero_d = hi_z;
      end else if (byte_op) begin
         zero_d = lo_z;
      end else begin
         zero_d = lo_z & hi_z;
      end
   end

   // Control outputs registered once per machine cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alu_function_select <= 4'h0;
         alu_carry_in <= 1'b0;
         alu_mode <= 1'b1;
         shifter_select <= 2'h0;
         instr_dependent_select <= 1'b0;
         byte_sign_extend <= 1'b0;
         high_byte_significant <= 1'b1;
         zero_detect <= 1'b0;
      end else begin
         alu_function_select <= fs_d;
         alu_carry_in <= cin_d;
         alu_mode <= mode_d;
         shifter_select <= shf_d;
         instr_dependent_select <= ins_dep_d;
         byte_sign_extend <= move_byte_instr;
         high_byte_significant <= ~byte_op | odd_byte_op |
                                  swap_bytes_instr;
         zero_detect <= zero_d;
      end
   end

   // Divide left save and odd-byte destination flags
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         divide_subtract_save <= 1'b0;
         odd_byte_dest <= 1'b0;
      end else begin
         if (divide_instr & div_sub_cycle) begin
            divide_subtract_save <= alu_carry_out;
         end
         if (dr_load) begin
            odd_byte_dest <= dr_load_bit;
         end
      end
   end

   // Bus slave: zero wait state, always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr_q <= {haddr[7:2], 2'b00};
         end
         if (addr_ok & ~hwrite) begin
            hrdata <= rd_mux(haddr[7:0]);
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // Read mux; a read right after a write to the same word
   // returns the old value, as the write lands one edge later
   function [31:0] rd_mux;
      input [7:0] a;
      reg [7:0] w;
      begin
         w = {a[7:2], 2'b00};
         rd_mux = 32'h0000_0000;
         if (w == `ASC_OFS_STATUS) begin
            rd_mux = {16'h0000,
                      odd_byte_dest,
                      divide_subtract_save,
                      zero_detect,
                      high_byte_significant,
                      byte_sign_extend,
                      instr_dependent_select,
                      shifter_select,
                      alu_mode,
                      alu_carry_in,
                      2'b00,
                      alu_function_select};
         end else if (w == `ASC_OFS_STICKY) begin
            rd_mux = {31'h0000_0000, unused_seen_q};
         end else if (asc_rom_hit(w)) begin
            rd_mux = {24'h00_0000, rom_q[asc_rom_idx(w)]};
         end
      end
   endfunction

   // Sticky flag for the unused field code; set wins over clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unused_seen_q <= 1'b0;
      end else if (alu_control_field == `ASC_ALU_CONTROL_FIELD_UNUSED) begin
         unused_seen_q <= 1'b1;
      end else if (wr_pend_q && (wr_addr_q == `ASC_OFS_STICKY) &&
                   hwdata[`ASC_STK_UNUSED]) begin
         unused_seen_q <= 1'b0;
      end
   end

   // ROM contents written in the data phase
   integer i;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < ROM_DEPTH; i = i + 1) begin
            rom_q[i] <= `ASC_ROM_RST;
         end
      end else if (wr_pend_q & rom_hit_wr) begin
         rom_q[wr_idx] <= hwdata[7:0];
      end
   end

endmodule // asc_alu_shift_ctrl

// >>> hw/asc_defines.vh
// Constants for the ALU and shifter control block
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// ALU control field codes
`define ASC_ALU_CONTROL_FIELD_NOT_A 3'h0
`define ASC_ALU_CONTROL_FIELD_PASS_B 3'h1
`define ASC_ALU_CONTROL_FIELD_A_C 3'h2
`define ASC_ALU_CONTROL_FIELD_AB_C 3'h3
`define ASC_ALU_CONTROL_FIELD_UNUSED 3'h4
`define ASC_ALU_CONTROL_FIELD_AA_C 3'h5
`define ASC_ALU_CONTROL_FIELD_A_MIN_B 3'h6
`define ASC_ALU_CONTROL_FIELD_INS_DEP 3'h7

// Function select codes, S3..S0 as active-high levels
`define ASC_FS_NOT_A 4'h0
`define ASC_FS_PASS_B 4'hA
`define ASC_FS_A 4'h0
`define ASC_FS_A_PLUS_B 4'h9
`define ASC_FS_A_PLUS_A 4'hC
`define ASC_FS_A_MIN_B 4'h6

// Shifter select code for byte swap
`define ASC_SHF_SWAP 2'h0

// Subsidiary ROM entry layout
`define ASC_ROM_FS_MSB 3
`define ASC_ROM_FS_LSB 0
`define ASC_ROM_MODE 4
`define ASC_ROM_CARRY 5
`define ASC_ROM_SHF_MSB 7
`define ASC_ROM_SHF_LSB 6
`define ASC_ROM_RST 8'h00

// AHB register byte offsets
`define ASC_OFS_STATUS 8'h00
`define ASC_OFS_STICKY 8'h04
`define ASC_OFS_ROM_BASE 8'h40
`define ASC_OFS_ROM_LAST 8'h7C

// Sticky register bit positions
`define ASC_STK_UNUSED 0

`endif

// >>> test/asc_alu_shift_ctrl_sva.sv
// Concurrent checks on the ALU and shifter control outputs
`timescale 1ns/1ps
module asc_alu_shift_ctrl_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] alu_control_field,
   input wire logic [1:0] shift_control_field,
   input wire logic swap_bytes_instr,
   input wire logic rotate_left_instr,
   input wire logic move_byte_instr,
   input wire logic divide_instr,
   input wire logic div_sub_cycle,
   input wire logic alu_carry_out,
   input wire logic dr_load,
   input wire logic dr_load_bit,
   input wire logic [3:0] alu_function_select,
   input wire logic alu_carry_in,
   input wire logic alu_mode,
   input wire logic [1:0] shifter_select,
   input wire logic instr_dependent_select,
   input wire logic byte_sign_extend,
   input wire logic divide_subtract_save,
   input wire logic odd_byte_dest
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_sel;
      alu_control_field == 3'h7 |=> instr_dependent_select;
   endproperty
   a_sel: assert property (p_sel) else $error("source select wrong");
   property p_main;
      alu_control_field != 3'h7 |=>
         shifter_select == $past(shift_control_field);
   endproperty
   a_main: assert property (p_main) else $error("shift field lost");
   property p_sub;
      alu_control_field == 3'h6 |=>
         alu_function_select == 4'h6 && !alu_mode && alu_carry_in;
   endproperty
   a_sub: assert property (p_sub) else $error("subtract decode wrong");
   property p_logic;
      alu_control_field[2:1] == 2'h0 |=> alu_mode;
   endproperty
   a_logic: assert property (p_logic) else $error("mode not logic");
   property p_swap;
      alu_control_field == 3'h7 && swap_bytes_instr |=>
         alu_function_select[3:2] == 2'h0 && shifter_select == 2'h0;
   endproperty
   a_swap: assert property (p_swap) else $error("swap not forced");
   property p_rol;
      alu_control_field == 3'h7 && rotate_left_instr |=> !alu_mode;
   endproperty
   a_rol: assert property (p_rol) else $error("rotate mode wrong");
   property p_sext;
      move_byte_instr |=> byte_sign_extend;
   endproperty
   a_sext: assert property (p_sext) else $error("byte sign missing");
   property p_save;
      divide_instr && div_sub_cycle |=>
         divide_subtract_save == $past(alu_carry_out);
   endproperty
   a_save: assert property (p_save) else $error("save not loaded");
   property p_obd;
      1'b1 |=> odd_byte_dest == ($past(dr_load) ?
         $past(dr_load_bit) : $past(odd_byte_dest));
   endproperty
   a_obd: assert property (p_obd) else $error("odd byte flag wrong");
endmodule // asc_alu_shift_ctrl_sva
bind asc_alu_shift_ctrl asc_alu_shift_ctrl_sva asc_alu_shift_ctrl_sva_i (.*);

// >>> test/asc_dp_model.sv
// Behavioural ALU model that returns the carry-out to the block
`timescale 1ns/1ps
module asc_dp_model (
   input wire logic [15:0] opnd_a,
   input wire logic alu_mode,
   output logic alu_carry_out
);
   // Only A plus A is modelled: its carry-out is the operand sign
   assign alu_carry_out = alu_mode ? 1'b0 : opnd_a[15];
endmodule // asc_dp_model

// >>> test/tb_top.sv
// Self-checking testbench for the ALU and shifter control block
`timescale 1ns/1ps
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, shift_control_field, shifter_select;
   logic [2:0] hsize, alu_control_field;
   logic [3:0] instr_index, alu_function_select;
   logic [15:0] shifter_output, opnd_a;
   logic cin_req, c_bit, sign_bit, low_word_msb, alu_carry_out;
   logic div_sub_cycle, swap_bytes_instr, byte_swap_req, add_carry_instr;
   logic sign_extend_word_instr, rotate_left_instr, subtract_carry_instr;
   logic divide_instr, combined_arith_shift_instr, move_byte_instr;
   logic byte_op, odd_byte_op, two_word_zero_check, z_bit, dr_load;
   logic dr_load_bit, alu_carry_in, alu_mode, instr_dependent_select;
   logic byte_sign_extend, high_byte_significant, zero_detect;
   logic divide_subtract_save, odd_byte_dest;
   int err_count, checks_done;
   logic [2:0] cd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
   logic [7:0] ex [6] = '{8'h09, 8'hA9, 8'h05, 8'h95, 8'hC5, 8'h65};
   logic [19:0] zv [7] = '{20'h80100, 20'h00100, 20'hC0001, 20'hC0100,
      20'h30000, 20'h20000, 20'h30001};
   logic [1:0] ze [7] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h3, 2'h1, 2'h1};
   asc_alu_shift_ctrl asc_alu_shift_ctrl_i (.*);
   asc_dp_model asc_dp_model_i (.*);
   assign hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Ready and read data taken at the rising edge, before it updates
   task wt;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 40) begin
         @(posedge hclk);
         n++;
      end
      if (hready !== 1'b1) begin
         err_count++;
         complete_run;
      end
      rd = hrdata;
   endtask
   task bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   function logic [7:0] ctl;
      ctl = {alu_function_select, alu_mode, alu_carry_in, shifter_select};
   endfunction
   task stp(input string n, input logic [7:0] e);
      @(posedge hclk);
      #1;
      chk(n, ctl(), e);
   endtask
   task t_plain;
      for (int i = 0; i < 6; i++) begin
         @(posedge hclk);
         alu_control_field <= cd[i];
         shift_control_field <= 2'h1;
         cin_req <= 1'b1;
         stp("plain", ex[i]);
      end
      @(posedge hclk);
      alu_control_field <= 3'h4;
      stp("unused", 8'h09);
      bus(1'b0, 32'h04, 32'h0);
      chk("sticky", rd, 32'h1);
      bus(1'b0, 32'h20, 32'h0);
      chk("unmapped", rd, 32'h0);
      $display("plain codes done");
   endtask
   task t_rom;
      bus(1'b1, 32'h4C, 32'hFF);
      bus(1'b0, 32'h4C, 32'h0);
      chk("rom", rd, 32'hFF);
      @(posedge hclk);
      alu_control_field <= 3'h7;
      instr_index <= 4'h3;
      c_bit <= 1'b1;
      rotate_left_instr <= 1'b1;
      stp("rol", 8'hF7);
      chk("insdep", instr_dependent_select, 1'b1);
      @(posedge hclk);
      rotate_left_instr <= 1'b0;
      subtract_carry_instr <= 1'b1;
      stp("sbc", 8'hF3);
      @(posedge hclk);
      subtract_carry_instr <= 1'b0;
      divide_instr <= 1'b1;
      low_word_msb <= 1'b1;
      stp("div", 8'hFF);
      @(posedge hclk);
      divide_instr <= 1'b0;
      swap_bytes_instr <= 1'b1;
      stp("swap", 8'h38);
      @(posedge hclk);
      swap_bytes_instr <= 1'b0;
      sign_extend_word_instr <= 1'b1;
      sign_bit <= 1'b1;
      stp("sxt", 8'hF3);
      $display("rom control done");
   endtask
   task t_zero;
      @(posedge hclk);
      sign_extend_word_instr <= 1'b0;
      alu_control_field <= 3'h0;
      for (int i = 0; i < 7; i++) begin
         @(posedge hclk);
         {byte_op, odd_byte_op, two_word_zero_check, z_bit,
            shifter_output} <= zv[i];
         @(posedge hclk);
         #1;
         chk("zero", {zero_detect, high_byte_significant}, ze[i]);
      end
      $display("zero detect done");
   endtask
   task t_flags;
      @(posedge hclk);
      alu_control_field <= 3'h5;
      {move_byte_instr, divide_instr, div_sub_cycle} <= 3'h7;
      {dr_load, dr_load_bit} <= 2'h3;
      opnd_a <= 16'h8000;
      @(posedge hclk);
      @(posedge hclk);
      {div_sub_cycle, dr_load, dr_load_bit} <= 3'h0;
      opnd_a <= 16'h0000;
      @(posedge hclk);
      #1;
      chk("flags", {byte_sign_extend, divide_subtract_save,
         odd_byte_dest}, 3'h7);
      $display("flags done");
   endtask
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize, instr_index,
         alu_control_field, shift_control_field, cin_req, c_bit, sign_bit,
         low_word_msb, div_sub_cycle, swap_bytes_instr, byte_swap_req,
         sign_extend_word_instr, rotate_left_instr, add_carry_instr,
         subtract_carry_instr, divide_instr, combined_arith_shift_instr,
         move_byte_instr, byte_op, odd_byte_op, shifter_output, opnd_a,
         two_word_zero_check, z_bit, dr_load, dr_load_bit} = '0;
      hsel = 1'b1;
      hsize = 3'h2;
      err_count = 0;
      checks_done = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_plain;
      t_rom;
      t_zero;
      t_flags;
      complete_run;
   end
endmodule // tb_top
